//--- epo_cfg.svh
// epo_cfg.svh: offsets, field positions, reset values and timing figures of the energy pulse stage
// assumes it is included by the top module of the stage
`ifndef EPO_CFG_SVH
`define EPO_CFG_SVH
`define EPO_CLK_HZ 125000000
`define EPO_CLK_MHZ 125
`define EPO_OSC_HZ 450000
`define EPO_LO_LIMIT_US 240000
`define EPO_LO_NOM_US 120000
`define EPO_CF_LIMIT_US 180000
`define EPO_CF_NOM_US 90000
`define EPO_CF_HF_NS 35000
`define EPO_CREEP_DIV 40960
`define EPO_BASE_EXP 19
`define EPO_CF_EXP_SCF1 12
`define EPO_CF_EXP_SCF0 13
`define EPO_CF_EXP_HF 5
`define EPO_ADDR_CTRL 4'h0
`define EPO_ADDR_STATE 4'h4
`define EPO_ADDR_IRQ_STAT 4'h8
`define EPO_ADDR_IRQ_MASK 4'hC
`define EPO_CTRL_RESET 3'h0
`define EPO_MASK_RESET 3'h0
`define EPO_IRQ_LO 0
`define EPO_IRQ_CF 1
`define EPO_IRQ_REV 2
`define EPO_ST_REV 0
`define EPO_ST_A 1
`define EPO_ST_B 2
`define EPO_ST_PHASE 3
`define EPO_RESP_OKAY 2'h0
`define EPO_RESP_SLVERR 2'h2
`endif

//--- epo_pkg.sv
// epo_pkg: types shared by the energy pulse stage
// assumes epo_cfg.svh holds the numbers
package epo_pkg;
   typedef struct packed {
      logic scale;
      logic rate_hi;
      logic rate_lo;
   } epo_ctrl_t;
   typedef struct packed {
      logic fire;
      logic neg;
   } epo_fire_t;
endpackage

//--- epo_pulse_stage.sv
// epo_pulse_stage: filtered real power to low-rate and calibration pulse outputs and a reverse-power flag
// assumes power_value comes from logic on core_clk; registers reached over AXI4-Lite
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "epo_cfg.svh"
module epo_pulse_stage #(
   parameter int PW = 24,
   parameter int OSC_DIV = `EPO_CLK_HZ / `EPO_OSC_HZ,
   parameter int LO_LIMIT = `EPO_LO_LIMIT_US * `EPO_CLK_MHZ,
   parameter int LO_NOM = `EPO_LO_NOM_US * `EPO_CLK_MHZ,
   parameter int CF_LIMIT = `EPO_CF_LIMIT_US * `EPO_CLK_MHZ,
   parameter int CF_NOM = `EPO_CF_NOM_US * `EPO_CLK_MHZ,
   parameter int CF_HF = (`EPO_CF_HF_NS * `EPO_CLK_MHZ + 999) / 1000
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic signed [PW-1:0] power_value,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic energy_pulse_a,
   output logic energy_pulse_b,
   output logic calib_pulse_out,
   output logic reverse_power_flag,
   output logic irq
);
   import epo_pkg::*;

   localparam int ACC_W = PW + 21;
   localparam logic [PW-1:0] CREEP_LIM = PW'((64'd1 << (PW - 1)) / `EPO_CREEP_DIV);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [ACC_W+1:0] step(input logic signed [ACC_W-1:0] acc,
         input logic signed [PW-1:0] p, input int sh);
      logic signed [ACC_W-1:0] t;
      logic signed [ACC_W-1:0] s;
      t = ACC_W'(64'd1 << sh);
      s = acc + ACC_W'(p);
      if (s >= t) begin
         step = {2'b10, s - t};
      end else if (s <= -t) begin
         step = {2'b11, s + t};
      end else begin
         step = {2'b00, s};
      end
   endfunction

   function automatic logic [31:0] width(input logic [31:0] per, input int lim, input int nom);
      if (per < 32'(lim)) begin
         width = (per > 32'h1) ? (per >> 1) : 32'h1;
      end else begin
         width = 32'(nom);
      end
   endfunction

   // ----------------------------------------
   // control and scaling
   // ----------------------------------------
   epo_ctrl_t ctrl;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [1:0] code;
   logic hf_mode;
   int lo_sh;
   int cf_sh;

   assign code = {ctrl.rate_hi, ctrl.rate_lo};
   assign hf_mode = !ctrl.scale && (code == 2'h3);

   always_comb begin
      lo_sh = PW - 1 + `EPO_BASE_EXP - int'(code);
      if (hf_mode) begin
         cf_sh = PW - 1 + `EPO_CF_EXP_HF;
      end else if (ctrl.scale) begin
         cf_sh = PW - 1 + `EPO_CF_EXP_SCF1;
      end else begin
         cf_sh = PW - 1 + `EPO_CF_EXP_SCF0;
      end
   end

   // ----------------------------------------
   // oscillator tick and creep detection
   // ----------------------------------------
   logic [15:0] div_cnt;
   logic tick;
   logic [PW-1:0] mag;
   logic creep;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (div_cnt == 16'(OSC_DIV - 1)) begin
         div_cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   assign mag = power_value[PW-1] ? PW'(-power_value) : power_value;
   assign creep = mag < CREEP_LIM;

   // ----------------------------------------
   // accumulators
   // ----------------------------------------
   logic signed [ACC_W-1:0] lo_acc;
   logic signed [ACC_W-1:0] cf_acc;
   epo_fire_t lo_ev;
   epo_fire_t cf_ev;
   logic lo_fire;
   logic cf_fire;

   assign lo_fire = lo_ev.fire;
   assign cf_fire = cf_ev.fire;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_acc <= '0;
         lo_ev <= '0;
      end else begin
         lo_ev.fire <= 1'b0;
         if (tick && !creep) begin
            {lo_ev, lo_acc} <= step(lo_acc, power_value, lo_sh);
         end
      end
   end

   // same power value, smaller threshold
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cf_acc <= '0;
         cf_ev <= '0;
      end else begin
         cf_ev.fire <= 1'b0;
         if (tick && !creep) begin
            {cf_ev, cf_acc} <= step(cf_acc, power_value, cf_sh);
         end
      end
   end

   // ----------------------------------------
   // low-rate pulse shaping
   // ----------------------------------------
   logic [31:0] lo_per;
   logic [31:0] lo_cnt;
   logic [31:0] lo_w;
   logic lo_phase;

   assign lo_w = width(lo_per, LO_LIMIT, LO_NOM);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_per <= 32'hFFFFFFFF;
         lo_cnt <= 32'h0;
         lo_phase <= 1'b0;
         energy_pulse_a <= 1'b1;
         energy_pulse_b <= 1'b1;
      end else if (lo_fire) begin
         lo_cnt <= lo_w;
         lo_per <= 32'h1;
         lo_phase <= !lo_phase;
         energy_pulse_a <= lo_phase;
         energy_pulse_b <= !lo_phase;
      end else begin
         if (lo_per != 32'hFFFFFFFF) begin
            lo_per <= lo_per + 32'h1;
         end
         if (lo_cnt != 32'h0) begin
            lo_cnt <= lo_cnt - 32'h1;
         end
         if (lo_cnt <= 32'h1) begin
            energy_pulse_a <= 1'b1;
            energy_pulse_b <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // calibration pulse shaping and reverse flag
   // ----------------------------------------
   logic [31:0] cf_per;
   logic [31:0] cf_cnt;
   logic [31:0] cf_w;

   assign cf_w = hf_mode ? 32'(CF_HF) : width(cf_per, CF_LIMIT, CF_NOM);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cf_per <= 32'hFFFFFFFF;
         cf_cnt <= 32'h0;
         calib_pulse_out <= 1'b0;
      end else if (cf_fire) begin
         cf_cnt <= cf_w;
         cf_per <= 32'h1;
         calib_pulse_out <= 1'b1;
      end else begin
         if (cf_per != 32'hFFFFFFFF) begin
            cf_per <= cf_per + 32'h1;
         end
         if (cf_cnt != 32'h0) begin
            cf_cnt <= cf_cnt - 32'h1;
         end
         if (cf_cnt <= 32'h1) begin
            calib_pulse_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reverse_power_flag <= 1'b0;
      end else if (cf_fire) begin
         reverse_power_flag <= cf_ev.neg;
      end
   end

   // ----------------------------------------
   // interrupt status, sticky, write one to clear
   // ----------------------------------------
   logic [2:0] ev_set;
   logic [2:0] w1c;

   always_comb begin
      ev_set = 3'h0;
      ev_set[`EPO_IRQ_LO] = lo_fire;
      ev_set[`EPO_IRQ_CF] = cf_fire;
      ev_set[`EPO_IRQ_REV] = cf_fire && (cf_ev.neg != reverse_power_flag);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~w1c) | ev_set;
         irq <= |(irq_stat & irq_mask);
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_have;
   logic w_have;
   logic [3:0] aw_q;
   logic [31:0] wd_q;
   logic w_strb0;
   logic wr_go;
   logic wr_hit;

   assign wr_go = aw_have && w_have && !s_axi_bvalid;
   assign wr_hit = (aw_q == `EPO_ADDR_CTRL) || (aw_q == `EPO_ADDR_STATE) ||
      (aw_q == `EPO_ADDR_IRQ_STAT) || (aw_q == `EPO_ADDR_IRQ_MASK);
   assign w1c = (wr_go && aw_q == `EPO_ADDR_IRQ_STAT && w_strb0) ? wd_q[2:0] : 3'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_q <= 4'h0;
         wd_q <= 32'h0;
         w_strb0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EPO_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_have && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            wd_q <= s_axi_wdata;
            w_strb0 <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (!w_have && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `EPO_RESP_OKAY : `EPO_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
         end
      end
   end

   // lane 0 strobe is stored with the data, since the write channel may be released before the write lands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `EPO_CTRL_RESET;
         irq_mask <= `EPO_MASK_RESET;
      end else if (wr_go && w_strb0) begin
         if (aw_q == `EPO_ADDR_CTRL) begin
            ctrl <= epo_ctrl_t'(wd_q[2:0]);
         end
         if (aw_q == `EPO_ADDR_IRQ_MASK) begin
            irq_mask <= wd_q[2:0];
         end
      end
   end

   logic [31:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_mux = 32'h0;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `EPO_ADDR_CTRL: rd_mux[2:0] = ctrl;
         `EPO_ADDR_STATE: begin
            rd_mux[`EPO_ST_REV] = reverse_power_flag;
            rd_mux[`EPO_ST_A] = energy_pulse_a;
            rd_mux[`EPO_ST_B] = energy_pulse_b;
            rd_mux[`EPO_ST_PHASE] = lo_phase;
         end
         `EPO_ADDR_IRQ_STAT: rd_mux[2:0] = irq_stat;
         `EPO_ADDR_IRQ_MASK: rd_mux[2:0] = irq_mask;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `EPO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? `EPO_RESP_OKAY : `EPO_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_ratio;
      !hf_mode |-> (lo_sh - cf_sh) == ((ctrl.scale ? 7 : 6) - int'(code));
   endproperty
   a_ratio: assert property (p_ratio) else $error("calibration ratio wrong");

   property p_hf_ratio;
      hf_mode |-> (lo_sh - cf_sh) == 11;
   endproperty
   a_hf_ratio: assert property (p_hf_ratio) else $error("high mode ratio not 2048");

   property p_full_scale;
      !hf_mode |-> cf_sh == (PW - 1 + (ctrl.scale ? 12 : 13));
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("full scale depends on rate code");

   property p_no_overlap;
      !(!energy_pulse_a && !energy_pulse_b);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both low-rate outputs active");

   property p_turn;
      lo_fire |=> (energy_pulse_a != energy_pulse_b) && (lo_phase != $past(lo_phase));
   endproperty
   a_turn: assert property (p_turn) else $error("low-rate outputs did not alternate");

   property p_lo_half;
      lo_fire && lo_per > 32'h1 && lo_per < 32'(LO_LIMIT) |=> lo_cnt == ($past(lo_per) >> 1);
   endproperty
   a_lo_half: assert property (p_lo_half) else $error("low-rate width not half period");

   property p_cf_nom;
      cf_fire && !hf_mode && cf_per >= 32'(CF_LIMIT) |=> calib_pulse_out && cf_cnt == 32'(CF_NOM);
   endproperty
   a_cf_nom: assert property (p_cf_nom) else $error("calibration width not nominal");

   property p_cf_half;
      cf_fire && !hf_mode && cf_per > 32'h1 && cf_per < 32'(CF_LIMIT) |=> cf_cnt == ($past(cf_per) >> 1);
   endproperty
   a_cf_half: assert property (p_cf_half) else $error("calibration width not half period");

   property p_cf_hf;
      cf_fire && hf_mode |=> calib_pulse_out && cf_cnt == 32'(CF_HF);
   endproperty
   a_cf_hf: assert property (p_cf_hf) else $error("high mode width wrong");

   property p_creep;
      tick && creep |=> !lo_fire && !cf_fire;
   endproperty
   a_creep: assert property (p_creep) else $error("pulse issued below creep limit");

   property p_rev;
      $changed(reverse_power_flag) |-> $past(cf_fire) && reverse_power_flag == $past(cf_ev.neg);
   endproperty
   a_rev: assert property (p_rev) else $error("reverse flag changed without pulse");

   property p_lo_low;
      $fell(energy_pulse_a) || $fell(energy_pulse_b) |-> $past(lo_fire);
   endproperty
   a_lo_low: assert property (p_lo_low) else $error("low-rate pulse without crossing");
endmodule

//--- epo_counter_model.sv
// epo_counter_model: pulse counter standing at the far side of the energy pulse stage
// assumes registered outputs on core_clk; a and b active low, calibration active high
`timescale 1ns/1ps
module epo_counter_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic energy_pulse_a,
   input wire logic energy_pulse_b,
   input wire logic calib_pulse_out,
   output int n_a,
   output int n_b,
   output int n_cf,
   output int lo_w1,
   output int lo_w,
   output int cf_w1,
   output int cf_w,
   output int alt_err
);
   logic pa;
   logic pb;
   logic pc;
   int lo_run;
   int cf_run;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {pa, pb, pc} <= 3'b110;
         {n_a, n_b, n_cf, lo_w1, lo_w, cf_w1, cf_w, alt_err, lo_run, cf_run} <= '0;
      end else begin
         pa <= energy_pulse_a;
         pb <= energy_pulse_b;
         pc <= calib_pulse_out;
         // a falling edge is one step; a must lead and b must follow
         if (pa && !energy_pulse_a) begin
            n_a <= n_a + 1;
            if (n_a != n_b) alt_err <= alt_err + 1;
         end
         if (pb && !energy_pulse_b) begin
            n_b <= n_b + 1;
            if (n_b + 1 != n_a) alt_err <= alt_err + 1;
         end
         if (!energy_pulse_a || !energy_pulse_b) begin
            lo_run <= lo_run + 1;
         end else if (lo_run != 0) begin
            lo_w <= lo_run;
            if (lo_w1 == 0) lo_w1 <= lo_run;
            lo_run <= 0;
         end
         if (!pc && calib_pulse_out) n_cf <= n_cf + 1;
         if (calib_pulse_out) begin
            cf_run <= cf_run + 1;
         end else if (cf_run != 0) begin
            cf_w <= cf_run;
            if (cf_w1 == 0) cf_w1 <= cf_run;
            cf_run <= 0;
         end
      end
   end
endmodule

//--- test_epo_pulse_stage.sv
// test_epo_pulse_stage: self-checking bench for the energy pulse stage
// assumes epo_pkg compiled first and epo_cfg.svh on the include path
`timescale 1ns/1ps
`include "epo_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_epo_pulse_stage;
   import epo_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic signed [23:0] power_value = '0;
   logic [3:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [3:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic energy_pulse_a, energy_pulse_b, calib_pulse_out, reverse_power_flag, irq;
   int n_a, n_b, n_cf, lo_w1, lo_w, cf_w1, cf_w, alt_err;
   int err_total = 0;
   int comparisons = 0;
   int bad;
   int n;
   logic [31:0] d;
   logic [1:0] rs;
   epo_ctrl_t ctl;

   always #4 core_clk = ~core_clk;

   epo_pulse_stage #(.OSC_DIV(1), .LO_NOM(500), .CF_LIMIT(5000), .CF_NOM(100),
      .CF_HF(10)) uut (.core_clk, .rst_n, .power_value, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .energy_pulse_a, .energy_pulse_b, .calib_pulse_out, .reverse_power_flag, .irq);

   epo_counter_model far_end (.core_clk, .rst_n, .energy_pulse_a, .energy_pulse_b, .calib_pulse_out,
      .n_a, .n_b, .n_cf, .lo_w1, .lo_w, .cf_w1, .cf_w, .alt_err);

   // ----------------------------------------
   // bus and wait tasks
   // ----------------------------------------
   task automatic results();
      $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic timeout();
      err_total++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 0, 1);
      results();
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      logic aw_p, w_p, ta, tw, tb, got;
      logic [1:0] r;
      int k;
      aw_p = 1'b1;
      w_p = 1'b1;
      got = 1'b0;
      r = '0;
      k = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got && k < 100) begin
         @(negedge core_clk);
         ta = aw_p && s_axi_awready === 1'b1;
         tw = w_p && s_axi_wready === 1'b1;
         tb = s_axi_bvalid === 1'b1;
         r = s_axi_bresp;
         @(posedge core_clk);
         k++;
         aw_p = aw_p && !ta;
         w_p = w_p && !tw;
         got = tb;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
      end
      if (!got) timeout();
      `CHK(r, er)
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
      logic ar_p, ta, got;
      int k;
      ar_p = 1'b1;
      got = 1'b0;
      k = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got && k < 100) begin
         @(negedge core_clk);
         ta = ar_p && s_axi_arready === 1'b1;
         got = s_axi_rvalid === 1'b1;
         v = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk);
         k++;
         ar_p = ar_p && !ta;
         if (ta) s_axi_arvalid <= 1'b0;
         if (got) s_axi_rready <= 1'b0;
      end
      if (!got) timeout();
   endtask

   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] r;
      rd(a, v, r);
      `CHK(v, e)
      `CHK(r, `EPO_RESP_OKAY)
   endtask

   // 0 low-rate pulses, 1 calibration pulses, 2 calibration idle, 3 low-rate idle
   function automatic int cur(input int which);
      case (which)
         0: return n_a + n_b;
         1: return n_cf;
         2: return (calib_pulse_out === 1'b0) ? 1 : 0;
         default: return (energy_pulse_a === 1'b1 && energy_pulse_b === 1'b1) ? 1 : 0;
      endcase
   endfunction

   task automatic wait_for(input int which, input int target, input int lim);
      int k;
      k = 0;
      while (k < lim && cur(which) < target) begin
         @(negedge core_clk);
         k++;
      end
      if (cur(which) < target) timeout();
      @(negedge core_clk);
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      `CHK({energy_pulse_a, energy_pulse_b, calib_pulse_out, reverse_power_flag, irq}, 5'b11000)
      rchk(`EPO_ADDR_CTRL, 32'h0);
      rchk(`EPO_ADDR_IRQ_MASK, 32'h0);
      rchk(`EPO_ADDR_IRQ_STAT, 32'h0);
      rd(`EPO_ADDR_STATE, d, rs);
      `CHK(d[2:0], 3'b110)
      rd(4'h2, d, rs);
      `CHK(rs, `EPO_RESP_SLVERR)
      `CHK(d, 32'h0)
      wr(4'h2, 32'h7, `EPO_RESP_SLVERR);
      // lane 0 strobe low: answered, register left alone
      s_axi_wstrb <= 4'h0;
      wr(`EPO_ADDR_CTRL, 32'h7, `EPO_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rchk(`EPO_ADDR_CTRL, 32'h0);
      // one below the no-load limit in the fastest mode
      ctl = '{scale: 1'b0, rate_hi: 1'b1, rate_lo: 1'b1};
      wr(`EPO_ADDR_CTRL, {29'h0, ctl}, `EPO_RESP_OKAY);
      rchk(`EPO_ADDR_CTRL, 32'h3);
      power_value <= 24'sh0000CB;
      repeat (1000) @(posedge core_clk);
      `CHK(n_a + n_b + n_cf, 0)
      // full scale forward: the 16th calibration crossing meets the first low-rate crossing
      ctl = '{scale: 1'b1, rate_hi: 1'b1, rate_lo: 1'b1};
      wr(`EPO_ADDR_CTRL, {29'h0, ctl}, `EPO_RESP_OKAY);
      power_value <= 24'sh7FFFFF;
      wait_for(0, 1, 70000);
      `CHK(n_cf, 16)
      `CHK(n_a, 1)
      `CHK(n_b, 0)
      `CHK(reverse_power_flag, 1'b0)
      rd(`EPO_ADDR_STATE, d, rs);
      `CHK(d[3:0], 4'hC)
      @(posedge core_clk);
      power_value <= '0;
      wait_for(3, 1, 3000);
      `CHK(lo_w1, 500)
      `CHK(lo_w, 500)
      `CHK(cf_w1, 100)
      `CHK(cf_w, 2048)
      `CHK(alt_err, 0)
      wait_for(2, 1, 3000);
      rchk(`EPO_ADDR_IRQ_STAT, 32'h3);
      wr(`EPO_ADDR_IRQ_MASK, 32'h2, `EPO_RESP_OKAY);
      @(negedge core_clk);
      `CHK(irq, 1'b1)
      wr(`EPO_ADDR_IRQ_STAT, 32'h3, `EPO_RESP_OKAY);
      rchk(`EPO_ADDR_IRQ_STAT, 32'h0);
      @(negedge core_clk);
      `CHK(irq, 1'b0)
      // reverse power in the high mode; the flag may only move with a calibration pulse
      ctl = '{scale: 1'b0, rate_hi: 1'b1, rate_lo: 1'b1};
      wr(`EPO_ADDR_CTRL, {29'h0, ctl}, `EPO_RESP_OKAY);
      power_value <= 24'sh800000;
      bad = 0;
      n = 0;
      while (calib_pulse_out !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
         if (calib_pulse_out !== 1'b1 && reverse_power_flag !== 1'b0) bad++;
      end
      `CHK(bad, 0)
      `CHK(reverse_power_flag, 1'b1)
      rd(`EPO_ADDR_IRQ_STAT, d, rs);
      `CHK(d[2], 1'b1)
      wait_for(1, n_cf + 4, 2000);
      wait_for(2, 1, 100);
      `CHK(cf_w, 10)
      `CHK(reverse_power_flag, 1'b1)
      @(posedge core_clk);
      power_value <= 24'sh7FFFFF;
      wait_for(1, n_cf + 1, 300);
      `CHK(reverse_power_flag, 1'b0)
      results();
   end
endmodule
